// *** dv/display_pipe_sync_output_bench.sv ***
// Self-checking bench for the display pipe sync output
`timescale 1ns/1ps
module display_pipe_sync_output_bench
	import dps_pkg::*;
;
	logic                   clk, rst, ext, hsync, vsync, scl_in, sda_in, scl_oe_n, sda_oe_n;
	dps_ahb_req_s           m, req;
	dps_ahb_rsp_s           rsp;
	dps_fetch_s [1:0]       fetch;
	logic [1:0][PAL_AW-1:0] pix;
	dps_video_s             av, bv, cv;
	logic [31:0]            q;
	logic [15:0]            seed;
	logic [5:0]             sc;
	int                     error_cnt, n_compared;
	int                     nat[8] = '{11, 6, 7, 9, 7, 4, 5, 6};
	int                     vga[8] = '{15, 8, 10, 13, 9, 6, 7, 9};
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always_comb begin
		req = m;
		req.hready = rsp.hreadyout;
	end
	dps_top dut (.clk(clk), .rst(rst), .ahb_req(req), .ahb_rsp(rsp), .plane_pix(pix), .plane_fetch(fetch),
		.analog_video(av), .port_b_video(bv), .port_c_video(cv), .hsync(hsync), .vsync(vsync),
		.ext_gfx_present(ext), .ddc_scl_in(scl_in), .ddc_scl_out(), .ddc_scl_oe_n(scl_oe_n),
		.ddc_sda_in(sda_in), .ddc_sda_out(), .ddc_sda_oe_n(sda_oe_n));
	dps_monitor_model mon (.plane_fetch(fetch), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
		.plane_pix(pix), .scl_in(scl_in), .sda_in(sda_in));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task test_done;
		if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		m <= '{1'b1, {24'h000000, a}, 2'h2, w, 3'h2, m.hwdata, 1'b1};
		do @(negedge clk); while (rsp.hreadyout !== 1'b1);
		@(posedge clk);
		m <= '{1'b0, m.haddr, 2'h0, w, 3'h2, d, 1'b1};
		do @(negedge clk); while (rsp.hreadyout !== 1'b1);
		@(posedge clk);
		q = rsp.hrdata;
	endtask
	task tset(input logic [7:0] b, input int t[8]);
		for (int i = 0; i < 4; i++) bus(1'b1, b + 8'(4 * i), {4'h0, 12'(t[2*i+1]), 4'h0, 12'(t[2*i])});
	endtask
	// Count one frame of pixels and compare sync pins with the analog stream sync flags
	task frame(input int t[8], input logic [5:0] s, input logic [1:0] inv, input logic [23:0] c);
		int k, nd, nh, nv;
		logic [1:0] pin;
		k = 0; nd = 0; nh = 0; nv = 0;
		while (k < (t[0] + 1) * (t[4] + 1)) begin
			@(negedge clk);
			if (av.valid === 1'b1) begin
				k++; nd += av.de; nh += av.hs; nv += av.vs;
				pin = {s[1] ? s[3] : av.vs ^ inv[1], s[0] ? s[2] : av.hs ^ inv[0]};
				chk({vsync, hsync}, pin);
				if (av.de) chk({av.r, av.g, av.b}, c);
				chk({bv.de, bv.hs, bv.vs}, ext ? 3'h0 : {av.de, av.hs, av.vs});
				chk({cv.de, cv.hs, cv.vs}, ext ? 3'h0 : {av.de, av.hs, av.vs});
			end
		end
		chk(nd, t[1] * t[5]);
		chk(nh, (t[3] - t[2]) * (t[4] + 1));
		chk(nv, (t[7] - t[6]) * (t[0] + 1));
	endtask
	initial begin
		m = '0; ext = 1'b0; rst = 1'b1; seed = 16'h2167; error_cnt = 0; n_compared = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({vsync, hsync}, 2'h3);
		bus(1'b0, REG_SYNC_CTRL, 32'h0);
		chk(q, 32'h0F);
		bus(1'b0, 8'hFC, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, REG_PAL_INDEX, 32'h0);
		bus(1'b1, REG_PAL_DATA, 32'h123456);
		bus(1'b1, REG_PAL_DATA, 32'h654321);
		tset(8'h40, nat);
		bus(1'b1, 8'h50, 32'h0);
		bus(1'b1, REG_PORT_ROUTE, 32'h70);
		bus(1'b1, REG_DISP_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			sc = i < 4 ? 6'(i << 4) : 6'(3 | (i - 4) << 2);
			seed = lfsr(seed);
			ext <= seed[0];
			bus(1'b1, REG_SYNC_CTRL, {26'h0, sc});
			repeat (300) @(posedge clk);
			frame(nat, sc, sc[5:4], 24'h123456);
			bus(1'b0, REG_STATUS, 32'h0);
			chk(q[0], ext);
		end
		tset(8'h20, vga);
		bus(1'b1, 8'h30, 32'h3);
		bus(1'b1, REG_DISP_CTRL, 32'h5);
		bus(1'b1, REG_SYNC_CTRL, 32'h0);
		repeat (400) @(posedge clk);
		frame(vga, 6'h0, 2'h3, 24'h123456);
		bus(1'b1, 8'h88, 32'h0006_0008);
		bus(1'b1, 8'h80, 32'h1);
		repeat (200) @(posedge clk);
		frame(vga, 6'h0, 2'h3, 24'h654321);
		bus(1'b1, REG_DDC_CMD, 32'h7A5);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(q[1], 1'h1);
		repeat (720) @(posedge clk);
		bus(1'b0, REG_STATUS, 32'h0);
		chk({q[15:8], q[2:1]}, {8'hA5, 2'h2});
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done;
	end
endmodule

// *** dv/dps_monitor_model.sv ***
// Monitor side model: plane surface and display channel pull-ups
`timescale 1ns/1ps
module dps_monitor_model
	import dps_pkg::*;
(
	input  wire dps_fetch_s [1:0]       plane_fetch,
	input  wire logic                   scl_oe_n,
	input  wire logic                   sda_oe_n,
	output      logic [1:0][PAL_AW-1:0] plane_pix,
	output      logic                   scl_in,
	output      logic                   sda_in
);
	// Answer index 1 in the fetch cycle, garbage otherwise
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			plane_pix[k] = plane_fetch[k].valid ? 8'h01 : ~plane_fetch[k].x[7:0];
		end
	end
	// Pull-ups only; monitor never answers
	assign scl_in = scl_oe_n;
	assign sda_in = sda_oe_n;
endmodule

// *** dv/dps_top_asserts.sv ***
// Assertion checker bound to the display pipe top
`timescale 1ns/1ps
module dps_top_asserts
	import dps_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst,
	input wire dps_ahb_req_s ahb_req,
	input wire dps_ahb_rsp_s ahb_rsp,
	input wire dps_video_s   analog_video,
	input wire dps_video_s   port_b_video,
	input wire logic         hsync,
	input wire logic         vsync,
	input wire logic         ext_gfx_present,
	input wire logic         ddc_scl_out,
	input wire logic         ddc_sda_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire tk = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
	property p_rst_sync; disable iff (1'b0) rst |=> hsync && vsync; endproperty
	a_rst_sync: assert property (p_rst_sync) else $error("sync low after reset");
	property p_resp; ahb_rsp.hresp == 1'b0; endproperty
	a_resp: assert property (p_resp) else $error("error response");
	property p_rd; tk && !ahb_req.hwrite |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout; endproperty
	a_rd: assert property (p_rd) else $error("read wait state wrong");
	property p_wr; tk && ahb_req.hwrite |=> ahb_rsp.hreadyout; endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_ext; ext_gfx_present [*8] |-> port_b_video == '0; endproperty
	a_ext: assert property (p_ext) else $error("digital port active while link taken");
	property p_black; !analog_video.de |-> {analog_video.r, analog_video.g, analog_video.b} == 24'h000000; endproperty
	a_black: assert property (p_black) else $error("colour outside active area");
	property p_od; !ddc_scl_out && !ddc_sda_out; endproperty
	a_od: assert property (p_od) else $error("display channel driven high");
	property p_hold; !analog_video.valid |-> $stable({analog_video.de, analog_video.hs, analog_video.vs}); endproperty
	a_hold: assert property (p_hold) else $error("sync moved between pixels");
	c_rd: cover property (tk && !ahb_req.hwrite);
	c_ext: cover property (ext_gfx_present && analog_video.valid);
	c_de: cover property (analog_video.valid && analog_video.de);
endmodule
bind dps_top dps_top_asserts u_chk (.clk(clk), .rst(rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
	.analog_video(analog_video), .port_b_video(port_b_video), .hsync(hsync), .vsync(vsync),
	.ext_gfx_present(ext_gfx_present), .ddc_scl_out(ddc_scl_out), .ddc_sda_out(ddc_sda_out));

// *** inc/dps_pkg.sv ***
// Constants and types for the display pipe and sync output block
//
// Summary of operation
// - Each sync output polarity is invertible, from legacy VGA or port control settings.
// - Each sync output can be disabled alone and then holds a chosen static level.
// - After reset both sync outputs are disabled and driven high.
// - Only separate horizontal and vertical sync; no composite or flat-panel sync.
// - Analog colour leaves as separate red, green and blue 8-bit values.
// - Analog path is rated for pixel rates up to 350 MHz.
// - In legacy VGA mode pipe 0 timing comes from the legacy display timing registers.
// - In legacy VGA mode pipe 0 ignores its native timing set but keeps its pixel divider; pipe 1 stays native.
// - Two independent pipes each combine their planes with their own timing generator.
// - Each port (analog, digital B, digital C) takes its stream from a chosen pipe.
// - Each plane binds to one pipe and fetches from a rectangular source surface.
// - Digital ports are unavailable while an external graphics device holds the link.
// - Each digital port is rated for pixel rates up to 225 megapixels per second.
// - Analog port display data channel clock and data sit on dedicated open-drain pins.
// - A hardware bus controller drives the display data channel at up to 400 kHz.
package dps_pkg;
	localparam int unsigned CLK_PERIOD_NS       = 40;
	localparam int unsigned DDC_BUS_KHZ         = 400;
	localparam int unsigned DDC_QUARTER_NS      = 1000000 / (DDC_BUS_KHZ * 4);
	localparam int unsigned DDC_QUARTER_CYC     = (DDC_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0]  DDC_Q_LAST          = 5'(DDC_QUARTER_CYC - 1);
	localparam int unsigned ANALOG_MAX_PIX_MHZ  = 350;
	localparam int unsigned DIGITAL_MAX_PIX_MHZ = 225;
	localparam int unsigned DAC_BITS            = 8;
	localparam int unsigned PAL_AW              = 8;
	localparam int unsigned PAL_DEPTH           = 256;
	localparam int unsigned PAL_DW              = 3 * DAC_BITS;
	localparam int unsigned TW                  = 12;
	localparam logic [TW-1:0] ONE_T             = 12'h001;

	localparam logic [7:0] REG_DISP_CTRL  = 8'h00;
	localparam logic [7:0] REG_PORT_ROUTE = 8'h04;
	localparam logic [7:0] REG_SYNC_CTRL  = 8'h08;
	localparam logic [7:0] REG_STATUS     = 8'h0C;
	localparam logic [7:0] REG_PAL_INDEX  = 8'h10;
	localparam logic [7:0] REG_PAL_DATA   = 8'h14;
	localparam logic [7:0] REG_DDC_CMD    = 8'h18;
	localparam logic [2:0] BLK_VGA        = 3'h1;
	localparam logic [2:0] BLK_TG0        = 3'h2;
	localparam logic [2:0] BLK_TG1        = 3'h3;
	localparam logic [2:0] BLK_PLANE      = 3'h4;
	localparam logic [2:0] TW_H           = 3'h0;
	localparam logic [2:0] TW_HS          = 3'h1;
	localparam logic [2:0] TW_V           = 3'h2;
	localparam logic [2:0] TW_VS          = 3'h3;
	localparam logic [2:0] TW_AUX         = 3'h4;
	localparam logic [1:0] PW_CFG         = 2'h0;
	localparam logic [1:0] PW_ORG         = 2'h1;
	localparam logic [1:0] PW_SIZE        = 2'h2;

	localparam int unsigned FLD_LO         = 0;
	localparam int unsigned FLD_HI         = 16;
	localparam int unsigned CTRL_PIPE_POS  = 0;
	localparam int unsigned CTRL_VGA_POS   = 2;
	localparam int unsigned ROUTE_SEL_POS  = 0;
	localparam int unsigned ROUTE_EN_POS   = 4;
	localparam int unsigned SC_HS_DIS      = 0;
	localparam int unsigned SC_VS_DIS      = 1;
	localparam int unsigned SC_HS_LVL      = 2;
	localparam int unsigned SC_VS_LVL      = 3;
	localparam int unsigned SC_HS_INV      = 4;
	localparam int unsigned SC_VS_INV      = 5;
	localparam logic [5:0]  SYNC_CTRL_RST  = 6'h0F;
	localparam int unsigned VM_HNEG_POS    = 0;
	localparam int unsigned VM_VNEG_POS    = 1;
	localparam int unsigned PAL_PIPE_POS   = 8;
	localparam int unsigned DDC_START_POS  = 8;
	localparam int unsigned DDC_STOP_POS   = 9;
	localparam int unsigned DDC_WR_POS     = 10;
	localparam int unsigned DDC_RD_POS     = 11;
	localparam int unsigned DDC_NAK_POS    = 12;
	localparam int unsigned ST_EXT_POS     = 0;
	localparam int unsigned ST_BUSY_POS    = 1;
	localparam int unsigned ST_NAK_POS     = 2;
	localparam int unsigned ST_RX_POS      = 8;
	localparam int unsigned ST_VBL_POS     = 16;
	localparam int unsigned PL_EN_POS      = 0;
	localparam int unsigned PL_PIPE_POS    = 1;
	localparam int unsigned PORT_AN        = 0;

	typedef struct packed {
		logic [TW-1:0] htot;
		logic [TW-1:0] hact;
		logic [TW-1:0] hss;
		logic [TW-1:0] hse;
		logic [TW-1:0] vtot;
		logic [TW-1:0] vact;
		logic [TW-1:0] vss;
		logic [TW-1:0] vse;
	} dps_timing_s;

	typedef struct packed {
		logic          en;
		logic          pipe;
		logic [TW-1:0] x0;
		logic [TW-1:0] y0;
		logic [TW-1:0] w;
		logic [TW-1:0] h;
	} dps_plane_s;

	typedef struct packed {
		logic                valid;
		logic                de;
		logic                hs;
		logic                vs;
		logic [DAC_BITS-1:0] r;
		logic [DAC_BITS-1:0] g;
		logic [DAC_BITS-1:0] b;
	} dps_video_s;

	typedef struct packed {
		logic          valid;
		logic [TW-1:0] x;
		logic [TW-1:0] y;
	} dps_fetch_s;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} dps_ahb_req_s;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} dps_ahb_rsp_s;

	typedef enum logic [3:0] {
		DDC_IDLE  = 4'h1,
		DDC_START = 4'h2,
		DDC_XFER  = 4'h4,
		DDC_STOP  = 4'h8
	} dps_ddc_e;
endpackage

// *** rtl/dps_palette_ram.sv ***
// Palette memory with registered read data
`timescale 1ns/1ps
module dps_palette_ram
	import dps_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [PAL_AW-1:0] waddr,
	input  wire logic [PAL_DW-1:0] wdata,
	input  wire logic [PAL_AW-1:0] raddr,
	output      logic [PAL_DW-1:0] rdata
);
	logic [PAL_DW-1:0] mem [PAL_DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// *** rtl/dps_top.sv ***
// Display pipes, port routing, sync outputs and display channel bus controller
`timescale 1ns/1ps
module dps_top
	import dps_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire dps_ahb_req_s           ahb_req,
	output      dps_ahb_rsp_s           ahb_rsp,
	input  wire logic [1:0][PAL_AW-1:0] plane_pix,
	output      dps_fetch_s [1:0]       plane_fetch,
	output      dps_video_s             analog_video,
	output      dps_video_s             port_b_video,
	output      dps_video_s             port_c_video,
	output      logic                   hsync,
	output      logic                   vsync,
	input  wire logic                   ext_gfx_present,
	input  wire logic                   ddc_scl_in,
	output      logic                   ddc_scl_out,
	output      logic                   ddc_scl_oe_n,
	input  wire logic                   ddc_sda_in,
	output      logic                   ddc_sda_out,
	output      logic                   ddc_sda_oe_n
);
	typedef struct packed {
		logic                  ap_valid;
		logic                  ap_write;
		logic [7:0]            ap_addr;
		logic                  rd_wait;
		logic [31:0]           hrdata;
		logic [1:0]            pipe_en;
		logic                  vga_mode;
		logic [2:0]            route_sel;
		logic [2:0]            route_en;
		logic [5:0]            sync_ctrl;
		logic [1:0]            vga_neg;
		dps_timing_s [2:0]     tset;
		logic [1:0][7:0]       div;
		logic [1:0][7:0]       divc;
		dps_plane_s [1:0]      plane;
		logic [7:0]            pal_idx;
		logic                  pal_pipe;
		logic [1:0][TW-1:0]    hc;
		logic [1:0][TW-1:0]    vc;
		logic [1:0][3:0]       d1;
		logic [1:0][3:0]       d2;
		dps_fetch_s [1:0]      fetch;
		dps_video_s [2:0]      vid;
		logic                  hsync;
		logic                  vsync;
		logic [1:0]            ext_s;
		logic [1:0]            sda_s;
		logic [1:0]            scl_s;
		dps_ddc_e              ddc_st;
		logic [4:0]            ddc_tick;
		logic [1:0]            ddc_ph;
		logic [3:0]            ddc_bit;
		logic [8:0]            ddc_sh;
		logic                  ddc_stop;
		logic                  ddc_go_xfer;
		logic                  scl_drv;
		logic                  sda_drv;
		logic [7:0]            ddc_rx;
		logic                  ddc_nak;
	} dps_state_s;

	dps_state_s                 s;
	dps_state_s                 next_s;
	logic [1:0][PAL_AW-1:0]     pal_raddr;
	logic [1:0][PAL_DW-1:0]     pal_rdata;
	logic [1:0]                 pal_we;
	logic                       hready_int;
	logic [1:0]                 pix_en;
	logic [1:0][2:0]            flg;
	dps_timing_s [1:0]          teff;
	logic [31:0]                w;
	logic [31:0]                rd;
	logic [2:0]                 a_blk;
	logic [2:0]                 a_wd;
	logic [1:0]                 a_set;
	logic                       pp;
	logic                       sel;
	logic                       hold;

	function automatic dps_timing_s eff_t(input logic vga, input dps_timing_s nat, input dps_timing_s leg);
		return vga ? leg : nat;
	endfunction

	function automatic logic [2*TW-1:0] tg_step(input dps_timing_s t, input logic [TW-1:0] h,
		input logic [TW-1:0] v);
		logic [TW-1:0] nh;
		logic [TW-1:0] nv;
		nh = h + ONE_T;
		nv = v;
		if (h >= t.htot) begin
			nh = '0;
			nv = (v >= t.vtot) ? '0 : v + ONE_T;
		end
		return {nv, nh};
	endfunction

	function automatic logic [2:0] tg_flags(input dps_timing_s t, input logic [TW-1:0] h, input logic [TW-1:0] v);
		return {(h < t.hact) && (v < t.vact), (h >= t.hss) && (h < t.hse), (v >= t.vss) && (v < t.vse)};
	endfunction

	function automatic logic pl_hit(input dps_plane_s pl, input logic [TW-1:0] h, input logic [TW-1:0] v);
		return pl.en && (h >= pl.x0) && ({1'b0, h} < {1'b0, pl.x0} + {1'b0, pl.w})
			&& (v >= pl.y0) && ({1'b0, v} < {1'b0, pl.y0} + {1'b0, pl.h});
	endfunction

	function automatic dps_timing_s t_wr(input dps_timing_s t, input logic [2:0] wd, input logic [31:0] d);
		t_wr = t;
		case (wd)
			TW_H: begin
				t_wr.htot = d[FLD_LO +: TW];
				t_wr.hact = d[FLD_HI +: TW];
			end
			TW_HS: begin
				t_wr.hss = d[FLD_LO +: TW];
				t_wr.hse = d[FLD_HI +: TW];
			end
			TW_V: begin
				t_wr.vtot = d[FLD_LO +: TW];
				t_wr.vact = d[FLD_HI +: TW];
			end
			TW_VS: begin
				t_wr.vss = d[FLD_LO +: TW];
				t_wr.vse = d[FLD_HI +: TW];
			end
			default: ;
		endcase
	endfunction

	function automatic logic [31:0] t_rd(input dps_timing_s t, input logic [2:0] wd);
		t_rd = 32'h0000_0000;
		case (wd)
			TW_H: {t_rd[FLD_HI +: TW], t_rd[FLD_LO +: TW]} = {t.hact, t.htot};
			TW_HS: {t_rd[FLD_HI +: TW], t_rd[FLD_LO +: TW]} = {t.hse, t.hss};
			TW_V: {t_rd[FLD_HI +: TW], t_rd[FLD_LO +: TW]} = {t.vact, t.vtot};
			TW_VS: {t_rd[FLD_HI +: TW], t_rd[FLD_LO +: TW]} = {t.vse, t.vss};
			default: ;
		endcase
	endfunction

	function automatic dps_video_s mk_vid(input logic [3:0] d, input logic [PAL_DW-1:0] c);
		mk_vid = '0;
		mk_vid.valid = d[3];
		mk_vid.de = d[2];
		mk_vid.hs = d[1];
		mk_vid.vs = d[0];
		if (d[2]) begin
			{mk_vid.r, mk_vid.g, mk_vid.b} = c;
		end
	endfunction

	always_comb begin
		next_s = s;
		pix_en = 2'h0;
		flg = '0;
		teff = '0;
		pal_raddr = '0;
		pal_we = 2'h0;
		w = ahb_req.hwdata;
		rd = 32'h0000_0000;
		a_blk = s.ap_addr[7:5];
		a_wd = s.ap_addr[4:2];
		a_set = (a_blk == BLK_VGA) ? 2'h2 : {1'b0, a_blk[0]};
		pp = 1'b0;
		sel = 1'b0;
		hold = 1'b0;
		hready_int = !(s.ap_valid && !s.ap_write && !s.rd_wait);

		// Pin synchronisers
		next_s.ext_s = {s.ext_s[0], ext_gfx_present};
		next_s.sda_s = {s.sda_s[0], ddc_sda_in};
		next_s.scl_s = {s.scl_s[0], ddc_scl_in};

		// Pixel enable dividers, timing generators
		for (int p = 0; p < 2; p++) begin
			teff[p] = eff_t(s.vga_mode && (p == 0), s.tset[p], s.tset[2]);
			pix_en[p] = s.pipe_en[p] && (s.divc[p] == s.div[p]);
			flg[p] = s.pipe_en[p] ? tg_flags(teff[p], s.hc[p], s.vc[p]) : 3'h0;
			if (!s.pipe_en[p]) begin
				next_s.divc[p] = 8'h00;
				next_s.hc[p] = '0;
				next_s.vc[p] = '0;
			end else if (pix_en[p]) begin
				next_s.divc[p] = 8'h00;
				{next_s.vc[p], next_s.hc[p]} = tg_step(teff[p], s.hc[p], s.vc[p]);
			end else begin
				next_s.divc[p] = s.divc[p] + 8'h01;
			end
			next_s.d1[p] = {pix_en[p], flg[p]};
			next_s.d2[p] = s.d1[p];
			if (s.fetch[0].valid && (s.plane[0].pipe == 1'(p))) begin
				pal_raddr[p] = plane_pix[0];
			end
			if (s.fetch[1].valid && (s.plane[1].pipe == 1'(p))) begin
				pal_raddr[p] = plane_pix[1];
			end
		end

		// Plane fetch requests
		for (int k = 0; k < 2; k++) begin
			pp = s.plane[k].pipe;
			next_s.fetch[k].valid = pix_en[pp] && flg[pp][2] && pl_hit(s.plane[k], s.hc[pp], s.vc[pp]);
			next_s.fetch[k].x = s.hc[pp] - s.plane[k].x0;
			next_s.fetch[k].y = s.vc[pp] - s.plane[k].y0;
		end

		// Port routing
		for (int q = 0; q < 3; q++) begin
			sel = s.route_sel[q];
			if (!s.route_en[q] || ((q != PORT_AN) && s.ext_s[1])) begin
				next_s.vid[q] = '0;
			end else if (s.d2[sel][3]) begin
				next_s.vid[q] = mk_vid(s.d2[sel], pal_rdata[sel]);
			end else begin
				next_s.vid[q].valid = 1'b0;
			end
		end

		// Analog sync pins, separate H and V only
		sel = s.route_sel[PORT_AN];
		next_s.hsync = s.sync_ctrl[SC_HS_DIS] ? s.sync_ctrl[SC_HS_LVL] :
			s.d2[sel][1] ^ ((s.vga_mode && !sel) ? s.vga_neg[VM_HNEG_POS] : s.sync_ctrl[SC_HS_INV]);
		next_s.vsync = s.sync_ctrl[SC_VS_DIS] ? s.sync_ctrl[SC_VS_LVL] :
			s.d2[sel][0] ^ ((s.vga_mode && !sel) ? s.vga_neg[VM_VNEG_POS] : s.sync_ctrl[SC_VS_INV]);

		// Display channel bus controller
		if (s.ddc_st != DDC_IDLE) begin
			next_s.ddc_tick = (s.ddc_tick == DDC_Q_LAST) ? 5'h00 : s.ddc_tick + 5'h01;
			if (s.ddc_tick == DDC_Q_LAST) begin
				unique case (s.ddc_st)
					DDC_START: begin
						unique case (s.ddc_ph)
							2'h0: begin
								next_s.sda_drv = 1'b0;
								next_s.scl_drv = 1'b0;
							end
							2'h1: next_s.sda_drv = 1'b1;
							2'h2: next_s.scl_drv = 1'b1;
							2'h3: next_s.ddc_st = s.ddc_go_xfer ? DDC_XFER : (s.ddc_stop ? DDC_STOP : DDC_IDLE);
						endcase
					end
					DDC_XFER: begin
						unique case (s.ddc_ph)
							2'h0: next_s.sda_drv = !s.ddc_sh[8];
							2'h1: next_s.scl_drv = 1'b0;
							2'h2: begin
								if (s.scl_s[1]) begin
									next_s.ddc_sh = {s.ddc_sh[7:0], s.sda_s[1]};
								end else begin
									hold = 1'b1;
								end
							end
							2'h3: begin
								next_s.scl_drv = 1'b1;
								if (s.ddc_bit == 4'h8) begin
									next_s.ddc_rx = s.ddc_sh[8:1];
									next_s.ddc_nak = s.ddc_sh[0];
									next_s.ddc_bit = 4'h0;
									next_s.ddc_st = s.ddc_stop ? DDC_STOP : DDC_IDLE;
								end else begin
									next_s.ddc_bit = s.ddc_bit + 4'h1;
								end
							end
						endcase
					end
					DDC_STOP: begin
						unique case (s.ddc_ph)
							2'h0: next_s.sda_drv = 1'b1;
							2'h1: next_s.scl_drv = 1'b0;
							2'h2: next_s.sda_drv = 1'b0;
							2'h3: next_s.ddc_st = DDC_IDLE;
						endcase
					end
					default: next_s.ddc_st = DDC_IDLE;
				endcase
				next_s.ddc_ph = hold ? s.ddc_ph : s.ddc_ph + 2'h1;
			end
		end

		// Bus read, one wait state
		case (s.ap_addr)
			REG_DISP_CTRL: begin
				rd[CTRL_PIPE_POS +: 2] = s.pipe_en;
				rd[CTRL_VGA_POS] = s.vga_mode;
			end
			REG_PORT_ROUTE: begin
				rd[ROUTE_SEL_POS +: 3] = s.route_sel;
				rd[ROUTE_EN_POS +: 3] = s.route_en;
			end
			REG_SYNC_CTRL: rd[5:0] = s.sync_ctrl;
			REG_STATUS: begin
				rd[ST_EXT_POS] = s.ext_s[1];
				rd[ST_BUSY_POS] = (s.ddc_st != DDC_IDLE);
				rd[ST_NAK_POS] = s.ddc_nak;
				rd[ST_RX_POS +: 8] = s.ddc_rx;
				rd[ST_VBL_POS] = s.vc[0] >= teff[0].vact;
				rd[ST_VBL_POS + 1] = s.vc[1] >= teff[1].vact;
			end
			REG_PAL_INDEX: begin
				rd[7:0] = s.pal_idx;
				rd[PAL_PIPE_POS] = s.pal_pipe;
			end
			default: begin
				if ((a_blk == BLK_VGA) || (a_blk == BLK_TG0) || (a_blk == BLK_TG1)) begin
					if (a_wd == TW_AUX) begin
						rd[7:0] = (a_set == 2'h2) ? {6'h00, s.vga_neg} : s.div[a_set[0]];
					end else begin
						rd = t_rd(s.tset[a_set], a_wd);
					end
				end else if (a_blk == BLK_PLANE) begin
					if (s.ap_addr[3:2] == PW_CFG) begin
						rd[PL_EN_POS] = s.plane[s.ap_addr[4]].en;
						rd[PL_PIPE_POS] = s.plane[s.ap_addr[4]].pipe;
					end else if (s.ap_addr[3:2] == PW_ORG) begin
						{rd[FLD_HI +: TW], rd[FLD_LO +: TW]} = {s.plane[s.ap_addr[4]].y0, s.plane[s.ap_addr[4]].x0};
					end else if (s.ap_addr[3:2] == PW_SIZE) begin
						{rd[FLD_HI +: TW], rd[FLD_LO +: TW]} = {s.plane[s.ap_addr[4]].h, s.plane[s.ap_addr[4]].w};
					end
				end
			end
		endcase
		if (s.ap_valid && !s.ap_write && !s.rd_wait) begin
			next_s.hrdata = rd;
			next_s.rd_wait = 1'b1;
		end

		// Bus write, zero wait
		if (s.ap_valid && s.ap_write) begin
			case (s.ap_addr)
				REG_DISP_CTRL: begin
					next_s.pipe_en = w[CTRL_PIPE_POS +: 2];
					next_s.vga_mode = w[CTRL_VGA_POS];
				end
				REG_PORT_ROUTE: begin
					next_s.route_sel = w[ROUTE_SEL_POS +: 3];
					next_s.route_en = w[ROUTE_EN_POS +: 3];
				end
				REG_SYNC_CTRL: next_s.sync_ctrl = w[5:0];
				REG_PAL_INDEX: begin
					next_s.pal_idx = w[7:0];
					next_s.pal_pipe = w[PAL_PIPE_POS];
				end
				REG_PAL_DATA: begin
					pal_we[s.pal_pipe] = 1'b1;
					next_s.pal_idx = s.pal_idx + 8'h01;
				end
				REG_DDC_CMD: begin
					if (s.ddc_st == DDC_IDLE) begin
						next_s.ddc_stop = w[DDC_STOP_POS];
						next_s.ddc_go_xfer = w[DDC_WR_POS] || w[DDC_RD_POS];
						next_s.ddc_sh = w[DDC_RD_POS] ? {8'hFF, w[DDC_NAK_POS]} : {w[7:0], 1'b1};
						next_s.ddc_ph = 2'h0;
						next_s.ddc_tick = 5'h00;
						next_s.ddc_bit = 4'h0;
						next_s.ddc_st = w[DDC_START_POS] ? DDC_START :
							(next_s.ddc_go_xfer ? DDC_XFER : (w[DDC_STOP_POS] ? DDC_STOP : DDC_IDLE));
					end
				end
				default: begin
					if ((a_blk == BLK_VGA) || (a_blk == BLK_TG0) || (a_blk == BLK_TG1)) begin
						if (a_wd != TW_AUX) begin
							next_s.tset[a_set] = t_wr(s.tset[a_set], a_wd, w);
						end else if (a_set == 2'h2) begin
							next_s.vga_neg = w[1:0];
						end else begin
							next_s.div[a_set[0]] = w[7:0];
						end
					end else if (a_blk == BLK_PLANE) begin
						if (s.ap_addr[3:2] == PW_CFG) begin
							next_s.plane[s.ap_addr[4]].en = w[PL_EN_POS];
							next_s.plane[s.ap_addr[4]].pipe = w[PL_PIPE_POS];
						end else if (s.ap_addr[3:2] == PW_ORG) begin
							next_s.plane[s.ap_addr[4]].x0 = w[FLD_LO +: TW];
							next_s.plane[s.ap_addr[4]].y0 = w[FLD_HI +: TW];
						end else if (s.ap_addr[3:2] == PW_SIZE) begin
							next_s.plane[s.ap_addr[4]].w = w[FLD_LO +: TW];
							next_s.plane[s.ap_addr[4]].h = w[FLD_HI +: TW];
						end
					end
				end
			endcase
		end

		// Address phase capture
		if (ahb_req.hready) begin
			next_s.ap_valid = ahb_req.hsel && ahb_req.htrans[1];
			next_s.ap_write = ahb_req.hwrite;
			next_s.ap_addr = ahb_req.haddr[7:0];
			next_s.rd_wait = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.sync_ctrl <= SYNC_CTRL_RST;
			s.hsync <= 1'b1;
			s.vsync <= 1'b1;
			s.ddc_st <= DDC_IDLE;
		end else begin
			s <= next_s;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_pal
		dps_palette_ram u_pal (
			.clk   (clk),
			.we    (pal_we[g]),
			.waddr (s.pal_idx),
			.wdata (ahb_req.hwdata[PAL_DW-1:0]),
			.raddr (pal_raddr[g]),
			.rdata (pal_rdata[g])
		);
	end

	assign ahb_rsp.hreadyout = hready_int;
	assign ahb_rsp.hresp     = 1'b0;
	assign ahb_rsp.hrdata    = s.hrdata;
	assign plane_fetch       = s.fetch;
	assign analog_video      = s.vid[0];
	assign port_b_video      = s.vid[1];
	assign port_c_video      = s.vid[2];
	assign hsync             = s.hsync;
	assign vsync             = s.vsync;
	assign ddc_scl_out       = 1'b0;
	assign ddc_scl_oe_n      = !s.scl_drv;
	assign ddc_sda_out       = 1'b0;
	assign ddc_sda_oe_n      = !s.sda_drv;
endmodule
